/* ofd_pkg.sv */
// package: constants and types for the operand field decoder
package ofd_pkg;
   // ***************************************
   // register bus map (byte addresses)
   // ***************************************
   localparam logic [7:0] OFD_REG_TBL_PTR = 8'h00;
   localparam logic [7:0] OFD_REG_TBL_LATCH = 8'h04;
   localparam logic [7:0] OFD_REG_PC = 8'h08;
   localparam logic [7:0] OFD_REG_CORE = 8'h0C;
   localparam logic [1:0] OFD_RESP_OKAY = 2'h0;
   localparam logic [1:0] OFD_RESP_SLVERR = 2'h2;
   // ***************************************
   // data space addresses of special registers
   // ***************************************
   localparam logic [7:0] OFD_F_PC_LOW = 8'h02;
   localparam logic [7:0] OFD_F_PC_HOLD = 8'h03;
   localparam logic [7:0] OFD_F_ALU_FLAGS = 8'h04;
   localparam logic [7:0] OFD_F_CPU_STATUS = 8'h06;
   localparam logic [7:0] OFD_F_ACC = 8'h0A;
   // ***************************************
   // flag and status bit positions
   // ***************************************
   localparam int OFD_FLAG_W = 4; // carry, digit carry, zero, overflow
   localparam int OFD_FLAG_ZERO = 2;
   localparam int OFD_GLINT_BIT = 4;
   // ***************************************
   // instruction field positions
   // ***************************************
   localparam int OFD_F_MSB = 7;
   localparam int OFD_DEST_BIT = 8;
   localparam int OFD_TBL_INC_BIT = 8;
   localparam int OFD_TBL_SEL_BIT = 9;
   localparam int OFD_TBL_WR_BIT = 10;
   localparam int OFD_TBL_LONG_BIT = 11;
   localparam int OFD_P_MSB = 12;
   localparam int OFD_B_MSB = 10;
   localparam int OFD_B_LSB = 8;
   localparam int OFD_K8_MSB = 7;
   localparam int OFD_K11_MSB = 10;
   // ***************************************
   // opcode class prefixes
   // ***************************************
   localparam logic [1:0] OFD_OP_BYTE = 2'h0;     // bits 15:14
   localparam logic [4:0] OFD_OP_SEL_BOTH = 5'h05; // bits 15:11, s form
   localparam logic [4:0] OFD_OP_TEST = 5'h06;    // bits 15:11, no result
   localparam logic [6:0] OFD_OP_MOVE_ACC = 7'h00; // bits 15:9, store acc or nop
   localparam logic [5:0] OFD_OP_CONST = 6'h0A;    // bits 15:10, clear or set f
   localparam logic [1:0] OFD_OP_PERIPH = 2'h1;    // bits 15:14
   localparam logic [2:0] OFD_OP_BIT = 3'h4;       // bits 15:13
   localparam logic [3:0] OFD_OP_BIT_MOD = 4'h8;   // bits 15:12
   localparam logic [3:0] OFD_OP_TABLE = 4'hA;     // bits 15:12
   localparam logic [2:0] OFD_OP_LIT11 = 3'h7;     // bits 15:13
   // ***************************************
   // decoded operand fields
   // ***************************************
   typedef struct packed {
      logic [7:0] file_addr;
      logic [4:0] periph_addr;
      logic [2:0] bit_sel;
      logic [10:0] literal;
      logic lit_wide;
      logic bit_op;
      logic rd_file;
      logic wr_file;
      logic wr_acc;
      logic wr_periph;
      logic tbl_op;
      logic tbl_high;
      logic tbl_inc;
   } ofd_dec_t;
endpackage

/* ofd_operand_field_decode.sv */
// operand field decoder with special register side effects and AXI4-Lite access
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE_01] general file operand is an 8-bit address, 00h to FFh
// [RULE_02] peripheral operand is a 5-bit address, 00h to 1Fh
// [RULE_03] table pointer increments after execution when i is 1, else holds
// [RULE_04] t selects table latch low byte at 0, high byte at 1
// [RULE_05] d at 0 writes the accumulator, at 1 the file register
// [RULE_06] s at 0 writes file and accumulator, at 1 only the file
// [RULE_07] bit instructions carry a 3-bit selector of the file bit
// [RULE_08] don't-care opcode bits are ignored
// [RULE_09] the instruction source encodes unused bits as 0
// [RULE_10] the instruction source never issues reserved opcodes
// [RULE_11] flag updates override bits written to the ALU flag register
// [RULE_12] reading program counter low copies the high byte to the holding latch
// [RULE_13] writing program counter low loads high byte from the holding latch
// [RULE_14] read-modify-write of counter low loads high byte from latch, result to low
// [RULE_15] global interrupt disable is bit 4 of the CPU status register
// [RULE_16] table pointer and table latch are each 16 bits wide
// [RULE_17] each instruction is one 16-bit word
// [RULE_18] literal fields are 8 or 11 bits wide
// [RULE_19] destination and byte select decode combinationally from the word
module ofd_operand_field_decode
   import ofd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   input wire logic [7:0] exec_result,
   input wire logic [OFD_FLAG_W-1:0] flag_upd_mask,
   input wire logic [OFD_FLAG_W-1:0] flag_upd_val,
   output ofd_dec_t dec_o,
   output logic [7:0] working_accumulator,
   output logic [15:0] table_pointer,
   output logic [15:0] prog_counter,
   output logic [7:0] table_byte_o,
   output logic global_irq_disable
);

   // merge a byte-enabled write into a 16-bit register
   function automatic logic [15:0] strb_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                                input logic [3:0] st);
      logic [15:0] v;
      v = old_v;
      if (st[0]) v[7:0] = wd[7:0];
      if (st[1]) v[15:8] = wd[15:8];
      return v;
   endfunction

   // ***************************************
   // instruction decode
   // ***************************************
   ofd_dec_t dec_c;
   logic [7:0] f_c;

   // combinational field decode of the fetched word
   always_comb begin
      dec_c = '0;
      f_c = instr_word[OFD_F_MSB:0]; // [RULE_01] [RULE_17]
      dec_c.file_addr = f_c;
      dec_c.periph_addr = instr_word[OFD_P_MSB:OFD_DEST_BIT]; // [RULE_02]
      dec_c.bit_sel = instr_word[OFD_B_MSB:OFD_B_LSB]; // [RULE_07]
      dec_c.lit_wide = (instr_word[15:13] == OFD_OP_LIT11);
      dec_c.literal = dec_c.lit_wide ? instr_word[OFD_K11_MSB:0] : {3'h0, instr_word[OFD_K8_MSB:0]}; // [RULE_18]
      if (instr_word[15:14] == OFD_OP_BYTE) begin
         if (instr_word[15:11] == OFD_OP_SEL_BOTH) begin
            dec_c.wr_file = 1'b1; // [RULE_06]
            dec_c.wr_acc = ~instr_word[OFD_DEST_BIT]; // [RULE_06] [RULE_19]
            dec_c.rd_file = (instr_word[15:10] != OFD_OP_CONST);
         end else if (instr_word[15:11] == OFD_OP_TEST) begin
            dec_c.rd_file = 1'b1; // compare, test, multiply: no result
         end else if (instr_word[15:9] == OFD_OP_MOVE_ACC) begin
            dec_c.wr_file = instr_word[OFD_DEST_BIT]; // store acc; else no operation
         end else begin
            dec_c.rd_file = 1'b1;
            dec_c.wr_file = instr_word[OFD_DEST_BIT]; // [RULE_05] [RULE_19]
            dec_c.wr_acc = ~instr_word[OFD_DEST_BIT]; // [RULE_05] [RULE_19]
         end
      end else if (instr_word[15:14] == OFD_OP_PERIPH) begin
         dec_c.rd_file = instr_word[13]; // file to peripheral
         dec_c.wr_file = ~instr_word[13];
         dec_c.wr_periph = instr_word[13];
      end else if (instr_word[15:13] == OFD_OP_BIT) begin
         dec_c.bit_op = 1'b1;
         dec_c.rd_file = 1'b1;
         dec_c.wr_file = (instr_word[15:12] == OFD_OP_BIT_MOD);
      end else if (instr_word[15:12] == OFD_OP_TABLE) begin
         dec_c.tbl_op = 1'b1;
         dec_c.tbl_high = instr_word[OFD_TBL_SEL_BIT]; // [RULE_04] [RULE_19]
         // increment bit is don't care on latch-only forms
         dec_c.tbl_inc = instr_word[OFD_TBL_LONG_BIT] & instr_word[OFD_TBL_INC_BIT]; // [RULE_08]
         dec_c.rd_file = instr_word[OFD_TBL_WR_BIT];
         dec_c.wr_file = ~instr_word[OFD_TBL_WR_BIT];
      end
   end

   // ***************************************
   // register bus slave
   // ***************************************
   logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [7:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic do_wr;
   // core state registers
   logic [7:0] acc_r, acc_nxt, flags_r, flags_nxt, cpu_status_r, cpu_status_nxt;
   logic [15:0] pc_r, pc_nxt, tbl_ptr_r, tbl_ptr_nxt, tbl_latch_r, tbl_latch_nxt;
   logic [7:0] hold_r, hold_nxt, tbl_byte_r, tbl_byte_nxt;
   ofd_dec_t dec_r;

   // write channel capture, response, read channel
   always_comb begin
      aw_full_nxt = aw_full_r;
      awaddr_nxt = awaddr_r;
      w_full_nxt = w_full_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      do_wr = aw_full_r && w_full_r && !bvalid_r;
      if (s_axi_awvalid && awready_r) begin
         aw_full_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_full_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
      if (do_wr) begin
         aw_full_nxt = 1'b0;
         w_full_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (awaddr_r == OFD_REG_TBL_PTR || awaddr_r == OFD_REG_TBL_LATCH) ?
                     OFD_RESP_OKAY : OFD_RESP_SLVERR;
      end
      if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = OFD_RESP_OKAY;
         unique case (s_axi_araddr)
            OFD_REG_TBL_PTR: rdata_nxt = {16'h0000, tbl_ptr_r};
            OFD_REG_TBL_LATCH: rdata_nxt = {16'h0000, tbl_latch_r};
            OFD_REG_PC: rdata_nxt = {8'h00, hold_r, pc_r};
            OFD_REG_CORE: rdata_nxt = {8'h00, cpu_status_r, flags_r, acc_r};
            default: begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = OFD_RESP_SLVERR;
            end
         endcase
      end
      awready_nxt = !aw_full_nxt;
      wready_nxt = !w_full_nxt;
      arready_nxt = !rvalid_nxt;
   end

   // bus registers
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_full_r <= 1'b0;
         awaddr_r <= 8'h00;
         w_full_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= 2'h0;
         rdata_r <= 32'h0000_0000;
      end else begin
         aw_full_r <= aw_full_nxt;
         awaddr_r <= awaddr_nxt;
         w_full_r <= w_full_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ***************************************
   // execution side effects
   // ***************************************
   logic [7:0] flag_base;
   logic [7:0] upd_mask8;
   logic pc_hit;
   // next state of accumulator, flags, counter, table; instruction beats bus write
   always_comb begin
      acc_nxt = acc_r;
      cpu_status_nxt = cpu_status_r;
      pc_nxt = pc_r;
      hold_nxt = hold_r;
      tbl_ptr_nxt = tbl_ptr_r;
      tbl_latch_nxt = tbl_latch_r;
      tbl_byte_nxt = tbl_byte_r;
      flag_base = flags_r;
      upd_mask8 = {{(8-OFD_FLAG_W){1'b0}}, flag_upd_mask};
      pc_hit = (f_c == OFD_F_PC_LOW);
      if (do_wr && awaddr_r == OFD_REG_TBL_PTR) tbl_ptr_nxt = strb_merge(tbl_ptr_r, wdata_r, wstrb_r);
      if (do_wr && awaddr_r == OFD_REG_TBL_LATCH) tbl_latch_nxt = strb_merge(tbl_latch_r, wdata_r, wstrb_r);
      if (instr_valid) begin
         if (dec_c.wr_acc || (dec_c.wr_file && f_c == OFD_F_ACC)) acc_nxt = exec_result;
         if (dec_c.wr_file && f_c == OFD_F_ALU_FLAGS) flag_base = exec_result;
         if (dec_c.wr_file && f_c == OFD_F_CPU_STATUS) cpu_status_nxt = exec_result;
         if (dec_c.wr_file && f_c == OFD_F_PC_HOLD) hold_nxt = exec_result;
         pc_nxt = 16'(pc_r + 16'h0001);
         if (pc_hit && dec_c.wr_file) pc_nxt = {hold_r, exec_result}; // [RULE_13] [RULE_14]
         else if (pc_hit && dec_c.rd_file) hold_nxt = pc_r[15:8]; // [RULE_12]
         if (dec_c.tbl_op) begin
            if (dec_c.rd_file && dec_c.tbl_high) tbl_latch_nxt[15:8] = exec_result; // [RULE_04] [RULE_16]
            if (dec_c.rd_file && !dec_c.tbl_high) tbl_latch_nxt[7:0] = exec_result; // [RULE_04]
            if (!dec_c.rd_file) tbl_byte_nxt = dec_c.tbl_high ? tbl_latch_r[15:8] : tbl_latch_r[7:0]; // [RULE_04]
            if (dec_c.tbl_inc) tbl_ptr_nxt = 16'(tbl_ptr_r + 16'h0001); // [RULE_03] [RULE_16]
         end
      end
      // instruction flag results override the written value
      flags_nxt = instr_valid ? ((flag_base & ~upd_mask8) | ({4'h0, flag_upd_val} & upd_mask8))
                              : flags_r; // [RULE_11]
   end

   // core registers
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_r <= 8'h00;
         flags_r <= 8'h00;
         cpu_status_r <= 8'h00;
         pc_r <= 16'h0000;
         hold_r <= 8'h00;
         tbl_ptr_r <= 16'h0000;
         tbl_latch_r <= 16'h0000;
         tbl_byte_r <= 8'h00;
         dec_r <= '0;
      end else begin
         acc_r <= acc_nxt;
         flags_r <= flags_nxt;
         cpu_status_r <= cpu_status_nxt;
         pc_r <= pc_nxt;
         hold_r <= hold_nxt;
         tbl_ptr_r <= tbl_ptr_nxt;
         tbl_latch_r <= tbl_latch_nxt;
         tbl_byte_r <= tbl_byte_nxt;
         dec_r <= instr_valid ? dec_c : dec_r;
      end
   end

   // output drive
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign dec_o = dec_r;
   assign working_accumulator = acc_r;
   assign table_pointer = tbl_ptr_r;
   assign prog_counter = pc_r;
   assign table_byte_o = tbl_byte_r;
   assign global_irq_disable = cpu_status_r[OFD_GLINT_BIT]; // [RULE_15]

   // ***************************************
   // assertions
   // ***************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_pc_low_write: assert property (instr_valid && pc_hit && dec_c.wr_file |=> // [RULE_13]
      pc_r == {$past(hold_r), $past(exec_result)}) else $error("counter low write wrong");
   a_pc_low_read: assert property (instr_valid && pc_hit && dec_c.rd_file && !dec_c.wr_file |=> // [RULE_12]
      hold_r == $past(pc_r[15:8])) else $error("holding latch not loaded on read");
   a_pc_rmw_high: assert property (instr_valid && pc_hit && dec_c.rd_file && dec_c.wr_file |=> // [RULE_14]
      pc_r[15:8] == $past(hold_r) && hold_r == $past(hold_r)) else $error("rmw high byte wrong");
   a_tbl_ptr_inc: assert property (instr_valid && dec_c.tbl_op && dec_c.tbl_inc |=> // [RULE_03]
      tbl_ptr_r == 16'($past(tbl_ptr_r) + 16'h0001)) else $error("table pointer not incremented");
   a_tbl_ptr_hold: assert property (instr_valid && dec_c.tbl_op && !dec_c.tbl_inc && !do_wr |=> // [RULE_03]
      $stable(tbl_ptr_r)) else $error("table pointer moved");
   a_tbl_byte_sel: assert property (instr_valid && dec_c.tbl_op && dec_c.rd_file |=> // [RULE_04]
      (dec_r.tbl_high ? tbl_latch_r[15:8] : tbl_latch_r[7:0]) == $past(exec_result))
      else $error("wrong table latch byte written");
   a_dest_acc: assert property (instr_valid && instr_word[15:14] == OFD_OP_BYTE && // [RULE_05]
      instr_word[15:11] != OFD_OP_TEST && instr_word[15:9] != OFD_OP_MOVE_ACC &&
      !instr_word[OFD_DEST_BIT] |=> acc_r == $past(exec_result)) else $error("acc not written for d 0");
   a_sel_both: assert property (instr_valid && instr_word[15:11] == OFD_OP_SEL_BOTH |-> // [RULE_06]
      dec_c.wr_file && (dec_c.wr_acc == !instr_word[OFD_DEST_BIT])) else $error("s select wrong");
   a_flag_override: assert property (instr_valid && dec_c.wr_file && f_c == OFD_F_ALU_FLAGS |=> // [RULE_11]
      ((flags_r ^ {4'h0, $past(flag_upd_val)}) & {4'h0, $past(flag_upd_mask)}) == 8'h00)
      else $error("flag update lost");
   a_dont_care: assert property (instr_valid && instr_word[15:12] == OFD_OP_TABLE && // [RULE_08]
      !instr_word[OFD_TBL_LONG_BIT] |=> !dec_r.tbl_inc) else $error("don't care bit used");
   a_bresp_hold: assert property (bvalid_r && !s_axi_bready |=> bvalid_r && $stable(bresp_r))
      else $error("write response dropped");

   c_pc_write: cover property (instr_valid && pc_hit && dec_c.wr_file);
   c_tbl_inc: cover property (instr_valid && dec_c.tbl_op && dec_c.tbl_inc ##1 instr_valid);
   c_clear_flags: cover property (instr_valid && f_c == OFD_F_ALU_FLAGS && dec_c.wr_file ##1
      flags_r[OFD_FLAG_ZERO]);
   c_bus_write: cover property (do_wr ##[1:4] s_axi_bvalid && s_axi_bready);

endmodule // ofd_operand_field_decode
`default_nettype wire

/* ofd_prog_mem.sv */
// program memory model that streams instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module ofd_prog_mem
   import ofd_pkg::*;
(
   input wire logic clk,
   output logic [15:0] instr_word,
   output logic instr_valid,
   output logic [7:0] exec_result,
   output logic [OFD_FLAG_W-1:0] flag_upd_mask,
   output logic [OFD_FLAG_W-1:0] flag_upd_val
);
   logic [31:0] prog [0:63]; // word, result, mask, value
   // idle lines at time zero
   initial begin
      instr_word = 16'h0000;
      instr_valid = 1'b0;
      exec_result = 8'h00;
      flag_upd_mask = 4'h0;
      flag_upd_val = 4'h0;
   end
   // stream entries with random stalls, word scrambled while idle
   task automatic run(input int n);
      for (int i = 0; i < n; i++) begin
         repeat ($urandom_range(0, 2)) begin
            instr_valid <= 1'b0;
            instr_word <= ~instr_word;
            @(posedge clk);
         end
         {instr_word, exec_result, flag_upd_mask, flag_upd_val} <= prog[i];
         instr_valid <= 1'b1;
         @(posedge clk);
      end
      instr_valid <= 1'b0;
      instr_word <= ~prog[n-1][31:16];
   endtask
endmodule // ofd_prog_mem
`default_nettype wire

/* tb_top.sv */
// testbench: decoder against a reference model, program memory and bus master
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ofd_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, instr_valid, global_irq_disable;
   logic [1:0] bresp, rresp;
   logic [15:0] instr_word, table_pointer, prog_counter, wq;
   logic [7:0] exec_result, working_accumulator, table_byte_o;
   logic [OFD_FLAG_W-1:0] flag_upd_mask, flag_upd_val;
   ofd_dec_t dec_o;
   int err_count = 0;
   int compares = 0;
   logic [15:0] tp_m = 16'h0, tl_m = 16'h0, pc_m = 16'h0;
   logic [7:0] acc_m = 8'h0, hold_m = 8'h0, fl_m = 8'h0, cs_m = 8'h0, tb_m = 8'h0;
   logic [31:0] dir [0:16] = '{32'h0103_5A00, 32'h0102_3000, 32'h0103_1100, 32'h7002_0000,
      32'h1502_4400, 32'h2904_0044, 32'h2806_1000, 32'hA620_BE00, 32'hA420_EF00, 32'hA220_0000,
      32'hA920_0000, 32'hAA20_0000, 32'h8520_0000, 32'hA120_0000, 32'h0E20_7700, 32'h0F20_6600,
      32'hE123_0000};
   // clock
   always #2.5 clk = ~clk;
   ofd_operand_field_decode i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .instr_word(instr_word),
      .instr_valid(instr_valid), .exec_result(exec_result), .flag_upd_mask(flag_upd_mask),
      .flag_upd_val(flag_upd_val), .dec_o(dec_o), .working_accumulator(working_accumulator),
      .table_pointer(table_pointer), .prog_counter(prog_counter), .table_byte_o(table_byte_o),
      .global_irq_disable(global_irq_disable));
   ofd_prog_mem i_mem (.clk(clk), .instr_word(instr_word), .instr_valid(instr_valid),
      .exec_result(exec_result), .flag_upd_mask(flag_upd_mask), .flag_upd_val(flag_upd_val));
   // ***************************************
   // reference model and compare
   // ***************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (err_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic step(input logic [15:0] w, input logic [7:0] r, input logic [3:0] m, input logic [3:0] v);
      logic wf, wa;
      wf = 1'b0;
      wa = 1'b0;
      if (w[15:11] == 5'h05) begin
         wf = 1'b1;
         wa = !w[8];
      end else if (w[15:14] == 2'h0 && w[15:11] != 5'h06) begin
         wf = w[8];
         wa = !w[8] && w[15:9] != 7'h00;
      end
      if (w[15:13] == 3'h3 && w[7:0] == OFD_F_PC_LOW) hold_m = pc_m[15:8];
      if (w[15:12] == 4'hA) begin
         if (w[10]) tl_m = w[9] ? {r, tl_m[7:0]} : {tl_m[15:8], r};
         else tb_m = w[9] ? tl_m[15:8] : tl_m[7:0];
         if (w[11] && w[8]) tp_m = tp_m + 16'h0001;
      end
      pc_m = (wf && w[7:0] == OFD_F_PC_LOW) ? {hold_m, r} : pc_m + 16'h0001;
      if (wf && w[7:0] == OFD_F_PC_HOLD) hold_m = r;
      if (wf && w[7:0] == OFD_F_CPU_STATUS) cs_m = r;
      if (wa || (wf && w[7:0] == OFD_F_ACC)) acc_m = r;
      if (wf && w[7:0] == OFD_F_ALU_FLAGS) fl_m = r;
      fl_m[3:0] = fl_m[3:0] & ~m | v & m;
   endtask
   // model each taken instruction, compare once the edge has landed
   always @(posedge clk) begin
      if (rst === 1'b0 && instr_valid === 1'b1) begin
         wq = instr_word;
         step(instr_word, exec_result, flag_upd_mask, flag_upd_val);
         #1;
         check(working_accumulator, acc_m);
         check(prog_counter, pc_m);
         check(table_pointer, tp_m);
         check(table_byte_o, tb_m);
         check(global_irq_disable, cs_m[OFD_GLINT_BIT]);
         check(dec_o.file_addr, wq[7:0]);
         check(dec_o.periph_addr, wq[12:8]);
         check(dec_o.bit_sel, wq[10:8]);
         check(dec_o.bit_op, wq[15:13] == 3'h4);
         check(dec_o.wr_periph, wq[15:13] == 3'h3);
         check(dec_o.tbl_inc, wq[15:12] == 4'hA && wq[11] && wq[8]);
         check(dec_o.tbl_high, wq[15:12] == 4'hA && wq[9]);
         check({dec_o.lit_wide, dec_o.literal}, wq[15:13] == 3'h7 ? {1'b1, wq[10:0]} : {4'h0, wq[7:0]});
      end
   end
   // ***************************************
   // bus master
   // ***************************************
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ha, hw, got;
      logic [1:0] rs;
      got = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40 && !got; n++) begin
         @(negedge clk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         got = bvalid && bready;
         rs = bresp;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!got) begin
         err_count++;
         tally_and_finish();
      end else
         check(rs, er);
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ha, got;
      logic [31:0] d;
      logic [1:0] rs;
      got = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40 && !got; n++) begin
         @(negedge clk);
         ha = arvalid && arready;
         got = rvalid && rready;
         d = rdata;
         rs = rresp;
         @(posedge clk);
         if (ha) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!got) begin
         err_count++;
         tally_and_finish();
      end else begin
         check(rs, er);
         check(d, ed);
      end
   endtask
   // ***************************************
   // scenarios
   // ***************************************
   initial begin
      void'($urandom(32'h1ee6042e));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      axi_rd(OFD_REG_TBL_PTR, 32'h0, OFD_RESP_OKAY);
      axi_wr(OFD_REG_TBL_PTR, 32'hABCD_FFFF, 4'hF, OFD_RESP_OKAY);
      tp_m = 16'hFFFF;
      for (int i = 0; i < 17; i++) i_mem.prog[i] = dir[i];
      i_mem.run(17);
      repeat (2) @(posedge clk);
      axi_rd(OFD_REG_TBL_PTR, {16'h0, tp_m}, OFD_RESP_OKAY);
      axi_rd(OFD_REG_TBL_LATCH, {16'h0, tl_m}, OFD_RESP_OKAY);
      axi_rd(OFD_REG_PC, {8'h0, hold_m, pc_m}, OFD_RESP_OKAY);
      axi_rd(OFD_REG_CORE, {8'h0, cs_m, fl_m, acc_m}, OFD_RESP_OKAY);
      axi_wr(OFD_REG_TBL_LATCH, 32'h1234_5678, 4'h2, OFD_RESP_OKAY);
      tl_m[15:8] = 8'h56;
      axi_rd(OFD_REG_TBL_LATCH, {16'h0, tl_m}, OFD_RESP_OKAY);
      axi_wr(OFD_REG_PC, 32'h0, 4'hF, OFD_RESP_SLVERR);
      axi_wr(8'h10, 32'h0, 4'hF, OFD_RESP_SLVERR);
      axi_rd(8'h10, 32'h0, OFD_RESP_SLVERR);
      axi_rd(OFD_REG_PC, {8'h0, hold_m, pc_m}, OFD_RESP_OKAY);
      for (int i = 0; i < 48; i++) i_mem.prog[i] = {2'b00, 5'($urandom_range(1, 25)), 1'($urandom),
         8'($urandom_range(32, 255)), 8'($urandom), 4'($urandom), 4'($urandom)};
      i_mem.run(48);
      repeat (2) @(posedge clk);
      axi_rd(OFD_REG_CORE, {8'h0, cs_m, fl_m, acc_m}, OFD_RESP_OKAY);
      axi_rd(OFD_REG_PC, {8'h0, hold_m, pc_m}, OFD_RESP_OKAY);
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
